// [logic/dbr_baud_gen.v]
// shared baud generator producing the sixteen-times sampling tick
`timescale 1ns/10ps
`default_nettype none
module dbr_baud_gen #(
  parameter DIV_W = 16
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire [DIV_W-1:0] baudDivisor,
  output reg              sampleTick
);
  // ----------------------------------------------------------------
  // divide counter
  // ----------------------------------------------------------------
  reg [DIV_W-1:0] count_q;   // cycles left until next tick

  // one tick every divisor cycles; divisor zero stops the tick
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_q    <= {DIV_W{1'b0}};
      sampleTick <= 1'b0;
    end else if (baudDivisor == {DIV_W{1'b0}}) begin
      count_q    <= {DIV_W{1'b0}};
      sampleTick <= 1'b0;
    end else if (count_q > baudDivisor) begin
      // a smaller divisor takes effect at once instead of after the old period
      count_q    <= baudDivisor;
      sampleTick <= 1'b0;
    end else if (count_q <= {{(DIV_W-1){1'b0}}, 1'b1}) begin
      count_q    <= baudDivisor;
      sampleTick <= 1'b1;
    end else begin
      count_q    <= count_q - {{(DIV_W-1){1'b0}}, 1'b1};
      sampleTick <= 1'b0;
    end
  end
endmodule // dbr_baud_gen
`default_nettype wire

// [logic/dbr_regs.vh]
// register offsets, field positions, reset values and timing counts of the debug uart receiver
`ifndef DBR_REGS_VH
`define DBR_REGS_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DBR_CONTROL_OFS    8'h00
`define DBR_MODE_OFS       8'h04
`define DBR_RXHOLD_OFS     8'h18
`define DBR_STATUS_OFS     8'h14
`define DBR_DIVISOR_OFS    8'h20
`define DBR_COMM_OFS       8'h24
// ----------------------------------------------------------------
// control command bits
// ----------------------------------------------------------------
`define DBR_CMD_RXRESET    2
`define DBR_CMD_RXENABLE   4
`define DBR_CMD_RXDISABLE  5
`define DBR_CMD_STCLEAR    8
// ----------------------------------------------------------------
// mode fields: parity select at bits 11:9
// ----------------------------------------------------------------
`define DBR_PAR_LSB        9
`define DBR_PAR_MSB        11
`define DBR_PAR_EVEN       3'h0
`define DBR_PAR_ODD        3'h1
`define DBR_PAR_SPACE      3'h2
`define DBR_PAR_MARK       3'h3
`define DBR_PAR_RESET      3'h4
// ----------------------------------------------------------------
// status bits
// ----------------------------------------------------------------
`define DBR_ST_RXREADY     0
`define DBR_ST_OVERRUN     5
`define DBR_ST_FRAME       6
`define DBR_ST_PARITY      7
`define DBR_ST_RXENABLED   16
`define DBR_ST_COMMRX      30
`define DBR_ST_COMMTX      31
// ----------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------
`define DBR_DIVISOR_RESET  16'h0000
`define DBR_OVERSAMPLE     16
`define DBR_START_MIN      7
`define DBR_FIRST_SAMPLE   24
`define DBR_BIT_SAMPLE     16
`endif

// [logic/dbr_sync.v]
// two flip-flop synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none
module dbr_sync #(
  parameter RESET_VAL = 1'b1
) (
  input  wire clk,
  input  wire resetn,
  input  wire asyncIn,
  output reg  syncOut
);
  reg meta_q;   // first stage, read only by second stage

  // two-stage capture
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q  <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule // dbr_sync
`default_nettype wire

// [logic/dbr_uart_rx.v]
// debug uart receiver with shared baud generator and register port
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "dbr_regs.vh"
module dbr_uart_rx #(
  parameter DIV_W = 16
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [31:0] regRdata,
  input  wire        serialInPin,
  output wire        serialOutPin,
  input  wire        commRx,
  input  wire        commTx,
  output wire        sampleTickOut,
  output wire        commIrq
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 3'h0;   // disabled
  localparam ST_HUNT  = 3'h1;   // looking for a start bit
  localparam ST_START = 3'h2;   // validating start low
  localparam ST_DATA  = 3'h3;   // sampling data bits
  localparam ST_PAR   = 3'h4;   // sampling parity bit
  localparam ST_STOP  = 3'h5;   // sampling stop bit

  // phase counts, cut to the tick counter width where used
  localparam [31:0] CNT_START_W = `DBR_START_MIN;                      // last start check
  localparam [31:0] CNT_VALID_W = `DBR_START_MIN + 1;                  // count on valid start
  localparam [31:0] CNT_LAST_W  = `DBR_FIRST_SAMPLE - 1;               // sample point
  localparam [31:0] CNT_REARM_W = `DBR_FIRST_SAMPLE - `DBR_BIT_SAMPLE; // rearm value

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [DIV_W-1:0] divisor_q;    // baud divisor register
  reg [2:0]       parSel_q;     // parity select
  reg             rx_enable_cmd_q;       // receiver enabled
  reg             disPend_q;    // disable requested mid character
  reg [2:0]       state_q;      // receiver state
  reg [4:0]       tickCnt_q;    // sample ticks in current phase
  reg [2:0]       bitCnt_q;     // data bit index
  reg [7:0]       shift_q;      // incoming data
  reg             parBit_q;     // sampled parity bit
  reg [7:0]       rxHold_q;     // holding register
  reg             rxReady_q;    // ready flag
  reg             overrun_q;    // sticky overrun
  reg             parErr_q;     // sticky parity error
  reg             frameErr_q;   // sticky framing error
  wire            rxSync;       // synchronised input
  wire            tick;         // sixteen-times sampling tick
  wire            commRxS;      // synchronised comm read full
  wire            commTxS;      // synchronised comm write empty

  // ----------------------------------------------------------------
  // decodes
  // ----------------------------------------------------------------
  wire wrCtl   = regWrite && (regAddr == `DBR_CONTROL_OFS);
  wire cmdRst  = wrCtl && regWdata[`DBR_CMD_RXRESET];
  wire cmdEn   = wrCtl && regWdata[`DBR_CMD_RXENABLE];
  wire cmdDis  = wrCtl && regWdata[`DBR_CMD_RXDISABLE];
  wire cmdClr  = wrCtl && regWdata[`DBR_CMD_STCLEAR];
  wire rdHold  = regRead && (regAddr == `DBR_RXHOLD_OFS);
  wire parOn   = (parSel_q == `DBR_PAR_EVEN) || (parSel_q == `DBR_PAR_ODD) ||
                 (parSel_q == `DBR_PAR_SPACE) || (parSel_q == `DBR_PAR_MARK);

  // expected parity bit for the received byte
  function expParity;
    input [2:0] sel;
    input [7:0] data;
    begin
      case (sel)
        `DBR_PAR_EVEN:  expParity = ^data;
        `DBR_PAR_ODD:   expParity = ~^data;
        `DBR_PAR_SPACE: expParity = 1'b0;
        `DBR_PAR_MARK:  expParity = 1'b1;
        default:        expParity = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // sub blocks
  // ----------------------------------------------------------------
  // one generator serves receiver and transmitter; tick exported
  dbr_baud_gen #(.DIV_W(DIV_W)) uBaud (
    .clk        (clk),
    .resetn     (resetn),
    .baudDivisor(divisor_q),
    .sampleTick (tick)
  );

  dbr_sync #(.RESET_VAL(1'b1)) uRxSync (
    .clk    (clk),
    .resetn (resetn),
    .asyncIn(serialInPin),
    .syncOut(rxSync)
  );

  dbr_sync #(.RESET_VAL(1'b0)) uCommRx (
    .clk    (clk),
    .resetn (resetn),
    .asyncIn(commRx),
    .syncOut(commRxS)
  );

  dbr_sync #(.RESET_VAL(1'b0)) uCommTx (
    .clk    (clk),
    .resetn (resetn),
    .asyncIn(commTx),
    .syncOut(commTxS)
  );

  assign sampleTickOut = tick;
  // transmitter lives elsewhere; line held idle high
  assign serialOutPin  = 1'b1;
  assign commIrq       = commRxS | commTxS;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // divisor and mode writes; any 16-bit divisor accepted
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divisor_q <= `DBR_DIVISOR_RESET;
      parSel_q  <= `DBR_PAR_RESET;
    end else begin
      if (regWrite && (regAddr == `DBR_DIVISOR_OFS))
        divisor_q <= regWdata[DIV_W-1:0];
      if (regWrite && (regAddr == `DBR_MODE_OFS))
        parSel_q <= regWdata[`DBR_PAR_MSB:`DBR_PAR_LSB];
    end
  end

  // ----------------------------------------------------------------
  // receiver state machine
  // ----------------------------------------------------------------
  // character completes at stop-bit sample; a reset command in the same cycle drops it
  wire charDone = tick && !cmdRst && (state_q == ST_STOP) &&
                  (tickCnt_q == CNT_LAST_W[4:0]);

  // no timeout or guard counters exist at all
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_enable_cmd_q    <= 1'b0;
      disPend_q <= 1'b0;
      state_q   <= ST_IDLE;
      tickCnt_q <= 5'h00;
      bitCnt_q  <= 3'h0;
      shift_q   <= 8'h00;
      parBit_q  <= 1'b0;
    end else if (cmdRst) begin
      // immediate halt, partial character dropped
      rx_enable_cmd_q    <= 1'b0;
      disPend_q <= 1'b0;
      state_q   <= ST_IDLE;
      tickCnt_q <= 5'h00;
    end else begin
      if (tick) begin
        case (state_q)
          ST_IDLE: begin
            tickCnt_q <= 5'h00;
          end
          ST_HUNT: begin
            tickCnt_q <= 5'h00;
            if (!rxSync)
              state_q <= ST_START;
          end
          ST_START: begin
            if (rxSync) begin
              // short space: back to hunting
              state_q   <= ST_HUNT;
              tickCnt_q <= 5'h00;
            end else if (tickCnt_q == CNT_START_W[4:0]) begin
              // low beyond seven ticks: valid start
              state_q   <= ST_DATA;
              tickCnt_q <= CNT_VALID_W[4:0];
              bitCnt_q  <= 3'h0;
            end else begin
              tickCnt_q <= tickCnt_q + 5'h01;
            end
          end
          ST_DATA: begin
            if (tickCnt_q == CNT_LAST_W[4:0]) begin
              // sample at 24 ticks, then rearm for 16
              shift_q   <= {rxSync, shift_q[7:1]};
              tickCnt_q <= CNT_REARM_W[4:0];
              bitCnt_q  <= bitCnt_q + 3'h1;
              if (bitCnt_q == 3'h7)
                state_q <= parOn ? ST_PAR : ST_STOP;
            end else begin
              tickCnt_q <= tickCnt_q + 5'h01;
            end
          end
          ST_PAR: begin
            if (tickCnt_q == CNT_LAST_W[4:0]) begin
              parBit_q  <= rxSync;
              tickCnt_q <= CNT_REARM_W[4:0];
              state_q   <= ST_STOP;
            end else begin
              tickCnt_q <= tickCnt_q + 5'h01;
            end
          end
          ST_STOP: begin
            if (tickCnt_q == CNT_LAST_W[4:0]) begin
              tickCnt_q <= 5'h00;
              state_q   <= (rx_enable_cmd_q && !disPend_q) ? ST_HUNT : ST_IDLE;
              disPend_q <= 1'b0;
            end else begin
              tickCnt_q <= tickCnt_q + 5'h01;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
      // commands come last so they win over the tick step; no tick is lost
      if (cmdEn && !cmdDis) begin
        rx_enable_cmd_q    <= 1'b1;
        disPend_q <= 1'b0;
        if (state_q == ST_IDLE || charDone)
          state_q <= ST_HUNT;
      end else if (cmdDis) begin
        rx_enable_cmd_q <= 1'b0;
        // idle, hunting, validating a start or a character ending now: stop at once
        if (state_q == ST_HUNT || state_q == ST_START || state_q == ST_IDLE || charDone) begin
          state_q <= ST_IDLE;
        end else begin
          disPend_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // status flags; setting wins over clearing
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxHold_q   <= 8'h00;
      rxReady_q  <= 1'b0;
      overrun_q  <= 1'b0;
      parErr_q   <= 1'b0;
      frameErr_q <= 1'b0;
    end else begin
      if (charDone) begin
        rxHold_q  <= shift_q;
        rxReady_q <= 1'b1;
      end else if (rdHold) begin
        rxReady_q <= 1'b0;
      end
      if (charDone && rxReady_q && !rdHold)
        overrun_q <= 1'b1;
      else if (cmdClr)
        overrun_q <= 1'b0;
      if (charDone && parOn && (parBit_q != expParity(parSel_q, shift_q)))
        parErr_q <= 1'b1;
      else if (cmdClr)
        parErr_q <= 1'b0;
      if (charDone && !rxSync)
        frameErr_q <= 1'b1;
      else if (cmdClr)
        frameErr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read port, data one cycle after strobe
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 32'h00000000;
    end else if (regRead) begin
      case (regAddr)
        `DBR_STATUS_OFS: begin
          regRdata                     <= 32'h00000000;
          regRdata[`DBR_ST_RXREADY]    <= rxReady_q;
          regRdata[`DBR_ST_OVERRUN]    <= overrun_q;
          regRdata[`DBR_ST_FRAME]      <= frameErr_q;
          regRdata[`DBR_ST_PARITY]     <= parErr_q;
          regRdata[`DBR_ST_RXENABLED]  <= rx_enable_cmd_q;
          regRdata[`DBR_ST_COMMRX]     <= commRxS;
          regRdata[`DBR_ST_COMMTX]     <= commTxS;
        end
        `DBR_RXHOLD_OFS:  regRdata <= {24'h000000, rxHold_q};
        `DBR_MODE_OFS:    regRdata <= {20'h00000, parSel_q, 9'h000};
        `DBR_DIVISOR_OFS: regRdata <= {{(32-DIV_W){1'b0}}, divisor_q};
        default:          regRdata <= 32'h00000000;
      endcase
    end else begin
      regRdata <= 32'h00000000;
    end
  end
endmodule // dbr_uart_rx
`default_nettype wire

// [tb/dbr_term_model.sv]
// remote serial terminal sending characters on the receive line
`timescale 1ns/10ps
`default_nettype none
module dbr_term_model (
  input  wire logic clk,
  output var  logic serialLine
);
  initial serialLine = 1'b1; // line idles high
  // hold one level for n clocks
  task automatic drive(input logic b, input int n);
    serialLine <= b;
    repeat (n) @(posedge clk);
  endtask
  // start, eight bits lsb first, optional parity, stop, idle bit
  task automatic send_char(input logic [7:0] v, input logic parOn, input logic parBit,
                           input logic stopBit, input int bitClks);
    drive(1'b0, bitClks);
    for (int i = 0; i < 8; i++) drive(v[i], bitClks);
    if (parOn) drive(parBit, bitClks);
    drive(stopBit, bitClks);
    drive(1'b1, bitClks);
  endtask
  // short low pulse on an idle line
  task automatic glitch(input int n);
    drive(1'b0, n);
    drive(1'b1, 64);
  endtask
endmodule // dbr_term_model
`default_nettype wire

// [tb/dbr_uart_rx_props.sv]
// assertions and covers on the debug uart receiver ports
`timescale 1ns/10ps
`default_nettype none
`include "dbr_regs.vh"
module dbr_uart_rx_props (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic        commRx,
  input wire logic        commTx,
  input wire logic        sampleTickOut,
  input wire logic        commIrq
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic [15:0] divQ;    // divisor as last written
  logic        enSeenQ; // receive enable written since reset
  wire         stRd;    // status read request
  wire         hdRd;    // holding read request
  assign stRd = regRead && regAddr == `DBR_STATUS_OFS;
  assign hdRd = regRead && regAddr == `DBR_RXHOLD_OFS;
  // follow writes seen on the register port
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divQ    <= 16'h0000;
      enSeenQ <= 1'b0;
    end else if (regWrite) begin
      if (regAddr == `DBR_DIVISOR_OFS) divQ <= regWdata[15:0];
      if (regAddr == `DBR_CONTROL_OFS && regWdata[`DBR_CMD_RXENABLE]) enSeenQ <= 1'b1;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_rdata_idle:
    assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_tick_off:
    assert property (divQ == 16'h0 && $past(divQ) == 16'h0 && $past(divQ, 2) == 16'h0
      |-> !sampleTickOut) else $error("tick with zero divisor");
  a_tick_pulse:
    assert property (sampleTickOut && divQ > 16'h1 && $past(divQ) > 16'h1 |=> !sampleTickOut)
    else $error("tick longer than one cycle");
  a_irq_set:
    assert property ((commRx || commTx) [*3] |-> commIrq) else $error("channel irq missing");
  a_irq_clear:
    assert property ((!commRx && !commTx) [*3] |-> !commIrq) else $error("channel irq stuck");
  a_comm_rx_bit:
    assert property (commRx [*3] ##0 stRd |=> regRdata[`DBR_ST_COMMRX])
    else $error("read-full status bit wrong");
  a_comm_tx_bit:
    assert property (!commTx [*3] ##0 stRd |=> !regRdata[`DBR_ST_COMMTX])
    else $error("write-empty status bit wrong");
  a_hold_upper:
    assert property ($past(hdRd) |-> regRdata[31:8] == 24'h0)
    else $error("holding read wider than eight bits");
  a_rx_off_reset:
    assert property (stRd && !enSeenQ |=> !regRdata[`DBR_ST_RXENABLED] && !regRdata[0])
    else $error("receiver active before enable");
  c_status_read: cover property (stRd);
  c_hold_read: cover property (hdRd);
  c_tick: cover property (sampleTickOut);
endmodule // dbr_uart_rx_props
`default_nettype wire

// [tb/tb_dbr_uart_rx.sv]
// self-checking bench for the debug uart receiver
`timescale 1ns/10ps
`default_nettype none
`include "dbr_regs.vh"
module tb_dbr_uart_rx;
  logic        clk = 1'b0;       // 50 MHz clock
  logic        resetn = 1'b0;    // active-low reset
  logic [7:0]  regAddr = 8'h00;  // register address
  logic [31:0] regWdata = 32'h0; // write data
  logic        regWrite = 1'b0;  // write strobe
  logic        regRead = 1'b0;   // read strobe
  logic        commRx = 1'b0;    // channel read-full
  logic        commTx = 1'b0;    // channel write-empty
  wire  [31:0] regRdata;         // read answer
  wire         serialInPin;      // line from terminal
  wire         serialOutPin;     // idle transmit line
  wire         sampleTickOut;    // sampling tick
  logic [63:0] expQ[$];          // expected value and mask
  string       nameQ[$];         // what each read checks
  logic        rdPend = 1'b0;    // answer due this cycle
  logic [63:0] cur;              // note being compared
  logic [7:0]  d;                // character under test
  int          failures = 0;
  int          samples_checked = 0;
  always #10 clk = ~clk;
  dbr_uart_rx i_dbr_uart_rx (.clk(clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .serialInPin(serialInPin), .serialOutPin(serialOutPin), .commRx(commRx), .commTx(commTx),
    .sampleTickOut(sampleTickOut), .commIrq());
  dbr_term_model i_dbr_term_model (.clk(clk), .serialLine(serialInPin));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      failures++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask
  // note the expected answer, then issue the read
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input string nm);
    expQ.push_back({e, m});
    nameQ.push_back(nm);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
  endtask
  // count ticks over n clocks
  task automatic ticks(input int n, input int e);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge clk);
      c += (sampleTickOut === 1'b1);
    end
    chk("tick count", e, c);
  endtask
  task automatic send(input logic [7:0] v, input logic po, input logic pb, input logic sb);
    i_dbr_term_model.send_char(v, po, pb, sb, 32);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // answer monitor: oldest note against read data
  // ----------------------------------------
  always @(posedge clk) begin
    if (rdPend) begin
      cur = expQ.pop_front();
      chk(nameQ.pop_front(), cur[63:32], regRdata & cur[31:0]);
    end
    rdPend <= regRead;
  end
  // run limit
  initial begin
    repeat (100000) @(posedge clk);
    $display("[ERR] run limit expected end seen none");
    failures++;
    print_verdict;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hF4E8));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(`DBR_STATUS_OFS, 32'h0, 32'h000100E1, "status");
    rd(`DBR_DIVISOR_OFS, 32'h0, 32'h0000FFFF, "divisor");
    rd(8'h0C, 32'h0, 32'hFFFFFFFF, "unmapped");
    ticks(40, 0);
    wr(`DBR_DIVISOR_OFS, 32'h0000FFFF);
    rd(`DBR_DIVISOR_OFS, 32'h0000FFFF, 32'h0000FFFF, "divisor");
    wr(`DBR_DIVISOR_OFS, 32'h00000003);
    repeat (8) @(posedge clk);
    ticks(60, 20);
    wr(`DBR_DIVISOR_OFS, 32'h00000002);
    repeat (8) @(posedge clk);
    ticks(40, 20);
    $display("test divisor done");
    send(8'hA5, 1'b0, 1'b0, 1'b1);
    rd(`DBR_STATUS_OFS, 32'h0, 32'h00010001, "status");
    wr(`DBR_CONTROL_OFS, 32'h1 << `DBR_CMD_RXENABLE);
    rd(`DBR_STATUS_OFS, 32'h00010000, 32'h00010001, "status");
    i_dbr_term_model.glitch(14);
    rd(`DBR_STATUS_OFS, 32'h0, 32'h00000001, "status");
    $display("test enable done");
    for (int p = 0; p < 5; p++) begin
      d = $urandom;
      wr(`DBR_MODE_OFS, p << `DBR_PAR_LSB);
      send(d, p < 4, (p == 0) ? ^d : (p == 1) ? ~^d : (p == 3), 1'b1);
      rd(`DBR_STATUS_OFS, 32'h00010001, 32'h000100E1, "status");
      rd(`DBR_RXHOLD_OFS, d, 32'h000000FF, "holding");
      rd(`DBR_STATUS_OFS, 32'h0, 32'h00000001, "status");
    end
    $display("test parity modes done");
    wr(`DBR_MODE_OFS, `DBR_PAR_EVEN << `DBR_PAR_LSB);
    send(8'h03, 1'b1, 1'b1, 1'b1);
    rd(`DBR_STATUS_OFS, 32'h81, 32'hE1, "status");
    rd(`DBR_RXHOLD_OFS, 32'h03, 32'hFF, "holding");
    send(8'h01, 1'b1, 1'b1, 1'b1);
    rd(`DBR_STATUS_OFS, 32'h81, 32'hE1, "status");
    rd(`DBR_RXHOLD_OFS, 32'h01, 32'hFF, "holding");
    wr(`DBR_CONTROL_OFS, 32'h1 << `DBR_CMD_STCLEAR);
    rd(`DBR_STATUS_OFS, 32'h0, 32'hE1, "status");
    wr(`DBR_MODE_OFS, `DBR_PAR_RESET << `DBR_PAR_LSB);
    send(8'h5A, 1'b0, 1'b0, 1'b0);
    rd(`DBR_STATUS_OFS, 32'h41, 32'hE1, "status");
    repeat (384) @(posedge clk);
    rd(`DBR_RXHOLD_OFS, 32'h5A, 32'hFF, "holding");
    wr(`DBR_CONTROL_OFS, 32'h1 << `DBR_CMD_STCLEAR);
    rd(`DBR_STATUS_OFS, 32'h0, 32'hE1, "status");
    send(8'h11, 1'b0, 1'b0, 1'b1);
    send(8'h22, 1'b0, 1'b0, 1'b1);
    rd(`DBR_STATUS_OFS, 32'h21, 32'hE1, "status");
    rd(`DBR_RXHOLD_OFS, 32'h22, 32'hFF, "holding");
    wr(`DBR_CONTROL_OFS, 32'h1 << `DBR_CMD_STCLEAR);
    rd(`DBR_STATUS_OFS, 32'h0, 32'hE1, "status");
    $display("test error flags done");
    fork
      send(8'hC3, 1'b0, 1'b0, 1'b1);
      begin
        repeat (160) @(posedge clk);
        wr(`DBR_CONTROL_OFS, 32'h1 << `DBR_CMD_RXDISABLE);
      end
    join
    rd(`DBR_STATUS_OFS, 32'h1, 32'h00010001, "status");
    rd(`DBR_RXHOLD_OFS, 32'hC3, 32'hFF, "holding");
    send(8'h3C, 1'b0, 1'b0, 1'b1);
    rd(`DBR_STATUS_OFS, 32'h0, 32'h1, "status");
    wr(`DBR_CONTROL_OFS, 32'h1 << `DBR_CMD_RXENABLE);
    fork
      send(8'h96, 1'b0, 1'b0, 1'b1);
      begin
        repeat (160) @(posedge clk);
        wr(`DBR_CONTROL_OFS, 32'h1 << `DBR_CMD_RXRESET);
      end
    join
    rd(`DBR_STATUS_OFS, 32'h0, 32'h00010001, "status");
    $display("test disable and reset done");
    repeat (4) begin
      commRx <= $urandom;
      commTx <= $urandom;
      repeat (4) @(posedge clk);
      rd(`DBR_STATUS_OFS, {commTx, commRx, 30'h0}, 32'hC0000000, "channel");
    end
    chk("serial out", 32'h1, {31'h0, serialOutPin});
    $display("test channel done");
    print_verdict;
  end
endmodule // tb_dbr_uart_rx
bind dbr_uart_rx dbr_uart_rx_props i_dbr_uart_rx_props (.clk(clk), .resetn(resetn),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .commRx(commRx), .commTx(commTx), .sampleTickOut(sampleTickOut),
  .commIrq(commIrq));
`default_nettype wire
